/* File: sim/oad_decode_asserts.sv */
// Purpose: Port-level checks on the operand address decoder
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound into every decoder instance
module oad_decode_asserts (
	// Clock and reset
	input logic        clk_sys,
	input logic        rst_b,
	// Watched ports
	input logic        byteOp,
	input logic        memAck,
	input logic        memReq_q,
	input logic        memWr_q,
	input logic [15:0] memAddr_q,
	input logic [2:0]  dstMode_q,
	input logic        deferred_q,
	input logic        isRegOperand_q,
	input logic [15:0] operand_q,
	input logic        done_q,
	input logic [15:0] pcValue_q,
	input logic [15:0] spValue_q
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic [15:0] fetchAddr_q; // Address of last answered PC read
	logic        fetchHit;    // Read at the PC answered this cycle
	assign fetchHit = memReq_q && memAck && !memWr_q && (memAddr_q == pcValue_q);
	// Remember where the last instruction-stream word came from
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) fetchAddr_q <= 16'h0000;
		else if (fetchHit) fetchAddr_q <= memAddr_q;
	end
	a_req_hold: assert property (memReq_q && !memAck |=> memReq_q && $stable(memAddr_q)
		&& $stable(memWr_q)) else $error("request moved before ack");
	a_done_pulse: assert property (done_q |=> !done_q) else $error("done too long");
	a_defer_flag: assert property (done_q |-> deferred_q == dstMode_q[0] && (!deferred_q
		|| dstMode_q == 3'h1 || $past(memReq_q && memAck && !memWr_q, 2)))
		else $error("deferred flag or pointer read wrong");
	a_reg_mode: assert property (done_q |-> isRegOperand_q == (dstMode_q == 3'h0)
		&& (!isRegOperand_q || $past(memReq_q && memAck && !memWr_q, 2)))
		else $error("register flag or timing wrong");
	a_byte_low: assert property (done_q && byteOp && isRegOperand_q |-> operand_q[15:8] == 8'h00)
		else $error("byte operand high bits set");
	a_pc_step: assert property (fetchHit |-> ##[1:2] pcValue_q == fetchAddr_q + 16'h0002)
		else $error("pc not advanced by two");
	a_even_ptr: assert property (!pcValue_q[0] && !spValue_q[0])
		else $error("pc or sp odd");
	a_reset_quiet: assert property ($rose(rst_b) |-> !memReq_q && !done_q && pcValue_q == 16'h0000)
		else $error("outputs busy after reset");
	c_index: cover property (done_q && dstMode_q == 3'h6);
	c_push: cover property (memReq_q && memWr_q && memAck);
	c_byte: cover property (done_q && byteOp && isRegOperand_q);
endmodule // oad_decode_asserts
bind oad_decode oad_decode_asserts i_oad_decode_asserts (.*);

/* File: sim/oad_mem_model.sv */
// Purpose: Memory model on the far side of the decoder's memory port
// Assumes: Word store addressed by bits 15:1, answer after ackWait cycles
// Notes:   Read data toggles outside the answer cycle, never stale
module oad_mem_model (
	// Clock, reset and pacing
	input  logic        clk_sys,
	input  logic        rst_b,
	input  logic [1:0]  ackWait,
	// Memory port
	input  logic        memReq_q,
	input  logic        memWr_q,
	input  logic [15:0] memAddr_q,
	input  logic [15:0] memWrData_q,
	output logic        memAck,
	output logic [15:0] memRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] memWord [0:32767]; // Word store
	logic [1:0]  waitCnt;           // Cycles waited so far
	// Pattern store: each word holds 0x0100 plus its address
	initial for (int i = 0; i < 32768; i++) memWord[i] = 16'h0100 + 16'(i * 2);
	// One-cycle acknowledge after the chosen wait
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			memAck    <= 1'b0;
			waitCnt   <= 2'h0;
			memRdData <= 16'h0000;
		end else begin
			memAck    <= 1'b0;
			memRdData <= ~memRdData; // Scrambled between answers
			if (memReq_q && !memAck) begin
				if (waitCnt == ackWait) begin
					memAck  <= 1'b1;
					waitCnt <= 2'h0;
					if (memWr_q) memWord[memAddr_q[15:1]] <= memWrData_q;
					else memRdData <= memWord[memAddr_q[15:1]];
				end else waitCnt <= waitCnt + 2'h1;
			end
		end
	end
endmodule // oad_mem_model

/* File: sim/test_operand_address_decode.sv */
// Purpose: Self-checking bench for the operand address decoder
// Assumes: Model store word at address a holds 0x0100 plus a
// Notes:   Table rows cover PC and stack forms; hand tests after
module test_operand_address_decode;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------
	// Signals
	// ------------------------------------------------
	logic        clk_sys = 1'b0, rst_b = 1'b0, startFetch = 1'b0, bankSel = 1'b0;
	logic        trapReq = 1'b0, byteOp = 1'b0, regWrEn = 1'b0;
	logic [1:0]  procMode = 2'h0, ackWait = 2'h0;
	logic [15:0] trapWord = 16'h0000, regWrData = 16'h0000;
	logic        memAck, memReq_q, memWr_q, done_q, deferred_q, isRegOperand_q;
	logic [15:0] memRdData, memAddr_q, memWrData_q, operand_q, operandAddr_q;
	logic [15:0] pcValue_q, spValue_q;
	logic [9:0]  opCode_q;
	logic [2:0]  dstMode_q, dstReg_q;
	int          bad_count = 0, samples_checked = 0, n;
	logic [15:0] pcExp = 16'h0000, spExp = 16'h0000;
	// Table rows: bit 16 is the byte flag, bits 15:0 the word
	logic [16:0] rows [10] = '{17'h00A17, 17'h00A1F, 17'h00A37, 17'h00A3F, 17'h00A0E,
		17'h18A16, 17'h18AB6, 17'h18A26, 17'h00A26, 17'h00A2E};
	oad_decode i_oad_decode (.*);
	oad_mem_model i_oad_mem_model (.*);
	// Clock
	always #5 clk_sys = ~clk_sys;
	// ------------------------------------------------
	// Tasks
	// ------------------------------------------------
	function automatic logic [15:0] memAt(input logic [15:0] a);
		memAt = 16'h0100 + {a[15:1], 1'b0};
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Place a word at the PC, start a decode, wait for done
	task automatic runInstr(input logic [15:0] w, input logic b, bk, input logic [1:0] pm);
		i_oad_mem_model.memWord[pcExp[15:1]] = w;
		@(posedge clk_sys) begin
			startFetch <= 1'b1;
			byteOp     <= b;
			bankSel    <= bk;
			procMode   <= pm;
		end
		@(posedge clk_sys) startFetch <= 1'b0;
		for (n = 0; n < 100 && done_q !== 1'b1; n++) @(posedge clk_sys) #1;
		if (n == 100) begin
			bad_count++;
			test_done();
		end
		pcExp += (w[5:3] >= 3'h6 || (w[2:0] == 3'h7 && w[5:4] == 2'h1)) ? 16'h0004 : 16'h0002;
	endtask
	// Decode one PC or stack form and compare fields, address, PC and SP
	task automatic doRow(input logic [16:0] row);
		logic [15:0] w, base, ea, x;
		w = row[15:0];
		base = (w[2:0] == 3'h7) ? pcExp + 16'h0002 : spExp;
		x = memAt(pcExp + 16'h0002) + ((w[2:0] == 3'h7) ? pcExp + 16'h0004 : spExp);
		case (w[5:3])
			3'h3: ea = memAt(base);
			3'h4: ea = base - 16'h0002;
			3'h5: ea = memAt(base - 16'h0002);
			3'h6: ea = x;
			3'h7: ea = memAt(x);
			default: ea = base;
		endcase
		if (w[2:0] == 3'h6 && w[5:4] == 2'h1) spExp += 16'h0002;
		if (w[2:0] == 3'h6 && w[5:4] == 2'h2) spExp -= 16'h0002;
		runInstr(w, row[16], 1'b0, 2'h0);
		chk("opcode", 16'(opCode_q), 16'(w[15:6]));
		chk("mode", 16'(dstMode_q), 16'(w[5:3]));
		chk("register", 16'(dstReg_q), 16'(w[2:0]));
		chk("deferred", 16'(deferred_q), 16'(w[3]));
		chk("address", operandAddr_q, ea);
		chk("pc", pcValue_q, pcExp);
		chk("sp", spValue_q, spExp);
	endtask
	// ------------------------------------------------
	// Main sequence
	// ------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys) #1;
		chk("reset pc", pcValue_q, 16'h0000);
		chk("reset request", 16'(memReq_q), 16'h0000);
		$display("test reset done");
		for (int k = 0; k < 10; k++) doRow(rows[k]);
		$display("test table done");
		// Register operand, banks, byte width and stepping
		runInstr(16'h0A03, 1'b0, 1'b0, 2'h0);
		chk("register flag", 16'(isRegOperand_q), 16'h0001);
		@(posedge clk_sys) begin
			regWrEn   <= 1'b1;
			regWrData <= 16'h12F4;
			ackWait   <= 2'h2;
		end
		@(posedge clk_sys) regWrEn <= 1'b0;
		runInstr(16'h0A03, 1'b0, 1'b0, 2'h0);
		chk("word operand", operand_q, 16'h12F4);
		runInstr(16'h0A03, 1'b1, 1'b0, 2'h0);
		chk("byte operand", operand_q, 16'h00F4);
		runInstr(16'h0A03, 1'b1, 1'b1, 2'h0);
		chk("other bank", operand_q, 16'h0000);
		runInstr(16'h8A13, 1'b1, 1'b0, 2'h0);
		chk("byte pointer", operandAddr_q, 16'h12F4);
		runInstr(16'h0A23, 1'b0, 1'b0, 2'h0);
		chk("step down", operandAddr_q, 16'h12F3);
		$display("test registers done");
		// Separate stack pointers per processor mode
		runInstr(16'h0A26, 1'b0, 1'b0, 2'h3);
		chk("user sp", spValue_q, 16'hFFFE);
		runInstr(16'h0A03, 1'b0, 1'b0, 2'h1);
		chk("supervisor sp", spValue_q, 16'h0000);
		runInstr(16'h0A03, 1'b0, 1'b0, 2'h0);
		chk("kernel sp", spValue_q, spExp);
		$display("test modes done");
		// Trap pushes state then PC onto the kernel stack
		@(posedge clk_sys) begin
			trapReq  <= 1'b1;
			trapWord <= 16'hC3A5;
		end
		@(posedge clk_sys) trapReq <= 1'b0;
		for (n = 0; n < 100 && (spValue_q !== spExp - 16'h0004 || memReq_q !== 1'b0); n++)
			@(posedge clk_sys) #1;
		if (n == 100) begin
			bad_count++;
			test_done();
		end
		chk("trap sp", spValue_q, spExp - 16'h0004);
		chk("pushed word", i_oad_mem_model.memWord[15'(spExp - 16'h0002 >> 1)], 16'hC3A5);
		chk("pushed pc", i_oad_mem_model.memWord[15'(spExp - 16'h0004 >> 1)], pcExp);
		$display("test trap done");
		test_done();
	end
endmodule // test_operand_address_decode

/* File: verilog/oad_decode.v */
// Purpose: Single-operand decode and destination operand resolution
// Assumes: Memory port answers a read with memAck, later cycle or same
// Notes:   Index word and deferred pointers are fetched through memory port
`include "oad_regs.vh"

module oad_decode (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// Control
	input  wire        startFetch,
	input  wire        bankSel,
	input  wire [1:0]  procMode,
	input  wire        trapReq,
	input  wire [15:0] trapWord,
	input  wire        byteOp,
	input  wire        regWrEn,
	input  wire [15:0] regWrData,
	// Memory port
	input  wire        memAck,
	input  wire [15:0] memRdData,
	output reg         memReq_q,
	output reg         memWr_q,
	output reg  [15:0] memAddr_q,
	output reg  [15:0] memWrData_q,
	// Decode results
	output reg  [9:0]  opCode_q,
	output reg  [2:0]  dstMode_q,
	output reg  [2:0]  dstReg_q,
	output reg         deferred_q,
	output reg         isRegOperand_q,
	output reg  [15:0] operand_q,
	output reg  [15:0] operandAddr_q,
	output reg         done_q,
	output reg  [15:0] pcValue_q,
	output reg  [15:0] spValue_q
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [2:0]  state_q;         // Sequencer state
	reg  [2:0]  state_d;         // Next state
	reg  [15:0] instr_q;         // Latched instruction
	reg  [15:0] pc_q;            // Program counter
	reg  [15:0] pc_d;            // Next program counter
	reg  [15:0] spKer_q;         // Kernel stack pointer
	reg  [15:0] spSup_q;         // Supervisor stack pointer
	reg  [15:0] spUsr_q;         // User stack pointer
	reg  [15:0] spNew;           // Stack pointer write value
	reg         spWr;            // Stack pointer write enable
	reg  [15:0] gprNew;          // General register write value
	reg         gprWr;           // General register write enable
	reg  [15:0] selVal;          // Selected register contents
	reg  [15:0] step;            // Pointer step size
	reg  [15:0] ptrAfter;        // Register after step
	reg  [15:0] addr;            // Effective address
	reg         trapPend_q;      // Second trap push pending
	wire [15:0] gprVal [0:11];   // Both banks
	wire [2:0]  rSel;            // Register select
	wire [2:0]  mode;            // Mode field
	wire [15:0] spCur;           // Active stack pointer
	wire [3:0]  gprIdx;          // Bank-adjusted index
	wire [15:0] spDec;           // Stack pointer minus two

	assign rSel   = instr_q[`OAD_REG_HI:`OAD_REG_LO];
	assign mode   = instr_q[`OAD_MODE_HI:`OAD_MODE_LO];
	assign gprIdx = {1'b0, rSel} + (bankSel ? 4'h6 : 4'h0);
	// One stack pointer per processor mode
	assign spCur  = (procMode == `OAD_PM_KERNEL) ? spKer_q :
			(procMode == `OAD_PM_SUPER) ? spSup_q : spUsr_q;
	// Pre-decremented pointer for pushes
	assign spDec  = spCur - `OAD_STEP_WORD;

	// ----------------------------------------
	// Register banks
	// ----------------------------------------
	// Index 0-5 primary bank, 6-11 alternate bank
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi = gi + 1) begin : gBank
			oad_gpr uGpr (
				.clk_sys (clk_sys),
				.rst_b   (rst_b),
				.wrEn    (gprWr && (gprIdx == gi)),
				.wrData  (gprNew),
				.value_q (gprVal[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Operand arithmetic
	// ----------------------------------------
	always @* begin
		// Selected register contents
		if (rSel == `OAD_SEL_PC) begin
			selVal = pc_q;
		end else if (rSel == `OAD_SEL_SP) begin
			selVal = spCur;
		end else begin
			selVal = gprVal[gprIdx];
		end
		// Step size
		if (byteOp && rSel != `OAD_SEL_SP && rSel != `OAD_SEL_PC) begin
			step = `OAD_STEP_BYTE;
		end else begin
			step = `OAD_STEP_WORD;
		end
		// Pointer motion
		// Modes two and three step up, four and five step down
		case (mode[2:1])
			2'h1: ptrAfter = selVal + step;
			2'h2: ptrAfter = selVal - step;
			default: ptrAfter = selVal;
		endcase
		// Address before deferral
		if (mode[2:1] == 2'h2) begin
			addr = ptrAfter;
		end else begin
			addr = selVal;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always @* begin
		state_d = state_q;
		pc_d    = pc_q;
		spWr    = 1'b0;
		spNew   = spCur;
		gprWr   = 1'b0;
		gprNew  = regWrData;
		case (state_q)
			`OAD_ST_FETCH: begin
				// Instruction word fetch
				// A pending trap wins over a new fetch
				if (trapReq && !memReq_q) begin
					spWr    = 1'b1;
					spNew   = spDec;
					state_d = `OAD_ST_PUSH;
				end else if (memReq_q && memAck) begin
					pc_d = pc_q + `OAD_STEP_WORD;
					if (memRdData[`OAD_MODE_HI:`OAD_MODE_LO] == 3'h0) begin
						state_d = `OAD_ST_DONE;
					end else if (memRdData[`OAD_MODE_HI:`OAD_MODE_HI-1] == 2'h3) begin
						state_d = `OAD_ST_EXT;
					end else if (memRdData[`OAD_MODE_HI:`OAD_MODE_HI-1] == 2'h0) begin
						// Register deferred needs no pointer read
						state_d = `OAD_ST_DONE;
					end else begin
						// Stepping deferred forms read a pointer first
						state_d = memRdData[`OAD_DEFER_BIT] ? `OAD_ST_IND :
							`OAD_ST_DONE;
					end
				end
			end
			`OAD_ST_EXT: begin
				// Index word fetched, PC advances past it
				if (memAck) begin
					pc_d    = pc_q + `OAD_STEP_WORD;
					state_d = mode[0] ? `OAD_ST_IND : `OAD_ST_DONE;
				end
			end
			`OAD_ST_IND: begin
				// Pointer read for deferred forms
				// Waits for the answer to the pointer request
				if (memReq_q && memAck) begin
					state_d = `OAD_ST_DONE;
				end
			end
			`OAD_ST_PUSH: begin
				// Second word of the trap frame
				if (memAck && !trapPend_q) begin
					state_d = `OAD_ST_FETCH;
				end else if (memAck) begin
					spWr  = 1'b1;
					spNew = spDec;
				end
			end
			`OAD_ST_DONE: begin
				// One completion cycle, then back to fetch
				state_d = `OAD_ST_FETCH;
			end
			default: state_d = `OAD_ST_FETCH;
		endcase
		// Register stepping from modes two to five, once per instruction
		if ((state_q == `OAD_ST_DONE) && (mode[2:1] == 2'h1 || mode[2:1] == 2'h2)) begin
			if (rSel == `OAD_SEL_SP) begin
				spWr  = 1'b1;
				spNew = ptrAfter;
			end else if (rSel == `OAD_SEL_PC) begin
				pc_d = (mode[2:1] == 2'h1) ? pc_q + `OAD_STEP_WORD : ptrAfter;
			end else begin
				gprWr  = 1'b1;
				gprNew = ptrAfter;
			end
		end else if (regWrEn && state_q == `OAD_ST_FETCH) begin
			// Direct writes only reach the six bank registers
			gprWr  = rSel < `OAD_SEL_SP;
			// Byte writes merge the low byte only
			gprNew = byteOp ? {selVal[15:8], regWrData[7:0]} : regWrData;
		end
	end

	// ----------------------------------------
	// Sequential state
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q        <= `OAD_ST_FETCH;
			instr_q        <= 16'h0000;
			pc_q           <= `OAD_PC_RST;
			spKer_q        <= `OAD_SP_RST;
			spSup_q        <= `OAD_SP_RST;
			spUsr_q        <= `OAD_SP_RST;
			trapPend_q     <= 1'b0;
			memReq_q       <= 1'b0;
			memWr_q        <= 1'b0;
			memAddr_q      <= 16'h0000;
			memWrData_q    <= 16'h0000;
			opCode_q       <= 10'h000;
			dstMode_q      <= 3'h0;
			dstReg_q       <= 3'h0;
			deferred_q     <= 1'b0;
			isRegOperand_q <= 1'b0;
			operand_q      <= 16'h0000;
			operandAddr_q  <= 16'h0000;
			done_q         <= 1'b0;
			pcValue_q      <= `OAD_PC_RST;
			spValue_q      <= `OAD_SP_RST;
		end else begin
			state_q   <= state_d;
			pc_q      <= pc_d;
			// Mirrors follow the next PC and the active stack pointer
			pcValue_q <= pc_d;
			spValue_q <= spWr ? spNew : spCur;
			done_q    <= (state_q == `OAD_ST_DONE);
			// Stack pointer bank write
			if (spWr) begin
				case (procMode)
					`OAD_PM_KERNEL: spKer_q <= spNew;
					`OAD_PM_SUPER:  spSup_q <= spNew;
					default:        spUsr_q <= spNew;
				endcase
			end
			// Memory request sequencing
			case (state_q)
				`OAD_ST_FETCH: begin
					if (trapReq && !memReq_q) begin
						memReq_q    <= 1'b1;
						memWr_q     <= 1'b1;
						memAddr_q   <= spDec;
						memWrData_q <= trapWord;
						trapPend_q  <= 1'b1;
					end else if (memReq_q && memAck) begin
						instr_q    <= memRdData;
						opCode_q   <= memRdData[`OAD_OPC_HI:`OAD_OPC_LO];
						dstMode_q  <= memRdData[`OAD_MODE_HI:`OAD_MODE_LO];
						dstReg_q   <= memRdData[`OAD_REG_HI:`OAD_REG_LO];
						deferred_q <= memRdData[`OAD_DEFER_BIT];
						memReq_q   <= (state_d == `OAD_ST_EXT);
						memAddr_q  <= pc_d;
						memWr_q    <= 1'b0;
					end else if (startFetch && !memReq_q) begin
						memReq_q  <= 1'b1;
						memWr_q   <= 1'b0;
						memAddr_q <= pc_q;
					end
				end
				`OAD_ST_EXT: begin
					if (memAck) begin
						// PC-relative uses PC already past the index word
						operandAddr_q <= memRdData + ((rSel == `OAD_SEL_PC) ? pc_d : selVal);
						memAddr_q     <= memRdData + ((rSel == `OAD_SEL_PC) ? pc_d : selVal);
						memReq_q      <= mode[0];
					end
				end
				`OAD_ST_IND: begin
					if (!memReq_q) begin
						// Pointer read once the instruction and PC have settled
						memReq_q  <= 1'b1;
						memWr_q   <= 1'b0;
						memAddr_q <= addr;
					end else if (memAck) begin
						operandAddr_q <= memRdData;
						memReq_q      <= 1'b0;
					end
				end
				`OAD_ST_PUSH: begin
					// First answer: queue the PC one word lower
					if (memAck && trapPend_q) begin
						memAddr_q   <= spDec;
						memWrData_q <= pc_q;
						trapPend_q  <= 1'b0;
					end else if (memAck) begin
						memReq_q <= 1'b0;
						memWr_q  <= 1'b0;
					end
				end
				default: begin
					// Completion and unused codes drop the request
					memReq_q <= 1'b0;
				end
			endcase
			// Operand and address for the non-indexed forms
			if (state_q == `OAD_ST_FETCH && memReq_q && memAck && !memWr_q) begin
				isRegOperand_q <= (memRdData[`OAD_MODE_HI:`OAD_MODE_LO] == 3'h0);
			end
			if (state_q != `OAD_ST_FETCH && state_q != `OAD_ST_EXT
					&& state_q != `OAD_ST_PUSH && mode[2:1] != 2'h3) begin
				if (mode == 3'h0) begin
					operand_q <= byteOp ? {8'h00, selVal[7:0]} : selVal;
				end else if (state_q == `OAD_ST_DONE && (!mode[0] || mode[2:1] == 2'h0)) begin
					// Modes one, two and four take the address from the register
					operandAddr_q <= addr;
				end
			end
		end
	end
endmodule // oad_decode

/* File: verilog/oad_gpr.v */
// Purpose: One 16-bit general register with write port
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Instantiated once per register of each bank
module oad_gpr (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_b,
	// Write port
	input  wire        wrEn,
	input  wire [15:0] wrData,
	// Stored value
	output reg  [15:0] value_q
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			value_q <= 16'h0000;
		end else if (wrEn) begin
			value_q <= wrData;
		end
	end
endmodule // oad_gpr

/* File: verilog/oad_regs.vh */
// Purpose: Constants for the operand address decode block
// Assumes: 16-bit instruction and data words
// Notes:   Definitions only
`ifndef OAD_REGS_VH
`define OAD_REGS_VH
// Instruction field positions
`define OAD_OPC_HI      15
`define OAD_OPC_LO      6
`define OAD_MODE_HI     5
`define OAD_MODE_LO     3
`define OAD_DEFER_BIT   3
`define OAD_REG_HI      2
`define OAD_REG_LO      0
// Register selects
`define OAD_SEL_SP      3'h6
`define OAD_SEL_PC      3'h7
// Processor modes
`define OAD_PM_KERNEL   2'h0
`define OAD_PM_SUPER    2'h1
`define OAD_PM_USER     2'h3
// Steps
`define OAD_STEP_WORD   16'h0002
`define OAD_STEP_BYTE   16'h0001
// Reset values
`define OAD_PC_RST      16'h0000
`define OAD_SP_RST      16'h0000
// Sequencer states
`define OAD_ST_FETCH    3'h0
`define OAD_ST_EXT      3'h1
`define OAD_ST_IND      3'h2
`define OAD_ST_DONE     3'h3
`define OAD_ST_PUSH     3'h4
`endif
